// file: common/fcsr_pkg.sv
// Function
// (R1) two-bit latency code in config bits 7:6 picks initial read dummy cycles
// (R2) protection-origin bit 5 set measures protected range from lowest address
// (R3) parameter-location bit 2 set puts 4-kB sectors at top; uniform reserves
// (R4) config bit 1 set runs the interface in quad mode, else dual/single
// (R5) freeze bit 0 set refuses block-protect, origin, location and otp changes; the code still lets bp_volatile_select be raised while frozen
// (R6) second status bit 7 set makes block erase 256 kB, else 64 kB
// (R7) second status bit 5 set makes idle io3 a reset input, else hold
// (R8) second status bit 1 reads one while an erase is suspended
// (R9) second status bit 0 reads one while a program is suspended
// (R10) register writes accepted only while the write-enable latch is set
// (R11) otp bits only go zero to one and persist across power cycles
package fcsr_pkg;

  // configuration register, msb first
  typedef struct packed {
    logic [1:0] latency_code;
    logic       protect_origin_select;
    logic       reserved;
    logic       bp_volatile_select;
    logic       param_sector_location;
    logic       quad_enable;
    logic       freeze;
  } fcsr_cfg_s;

  // second status register, msb first
  typedef struct packed {
    logic       erase_size_select;
    logic       page_wrap_select;
    logic       io3_function_select;
    logic [2:0] reserved;
    logic       erase_suspended_flag;
    logic       program_suspended_flag;
  } fcsr_sr2_s;

  // image kept in non-volatile storage
  typedef struct packed {
    fcsr_cfg_s cfg;
    fcsr_sr2_s sr2;
  } fcsr_nv_s;

  localparam int FCSR_LATENCY_HIGH_BIT = 7;
  localparam int FCSR_LATENCY_LOW_BIT  = 6;
  localparam int FCSR_PROT_ORIGIN_BIT  = 5;
  localparam int FCSR_BP_VOLATILE_BIT  = 3;
  localparam int FCSR_PARAM_LOC_BIT    = 2;
  localparam int FCSR_QUAD_BIT         = 1;
  localparam int FCSR_FREEZE_BIT       = 0;
  localparam int FCSR_ERASE_SIZE_BIT   = 7;
  localparam int FCSR_PAGE_WRAP_BIT    = 6;
  localparam int FCSR_IO3_FUNC_BIT     = 5;
  localparam int FCSR_ERASE_SUSP_BIT   = 1;
  localparam int FCSR_PROG_SUSP_BIT    = 0;

  localparam logic [7:0] FCSR_CFG_RESET = 8'h00;
  localparam logic [7:0] FCSR_SR2_RESET = 8'h00;
  localparam int         FCSR_SYNC_WIDTH = 1;

  typedef enum logic [2:0] {
    FCSR_ST_LOAD   = 3'b001,
    FCSR_ST_IDLE   = 3'b010,
    FCSR_ST_COMMIT = 3'b100
  } fcsr_state_e;

endpackage : fcsr_pkg

// file: rtl/fcsr_sync2.sv
`timescale 1ns/100ps
module fcsr_sync2
  import fcsr_pkg::*;
#(
  parameter int WIDTH = FCSR_SYNC_WIDTH
)(
  input  wire logic             i_sys_clk,
  input  wire logic             i_reset,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] stage_one;

  // first stage feeds only the second stage
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1)
    begin : g_bit
      always_ff @(posedge i_sys_clk)
      begin
        if (i_reset)
        begin
          stage_one[gi] <= 1'b1;
          o_sync[gi]    <= 1'b1;
        end
        else
        begin
          stage_one[gi] <= i_async[gi];
          o_sync[gi]    <= stage_one[gi];
        end
      end
    end
  endgenerate

endmodule : fcsr_sync2

// file: rtl/fcsr_regs.sv
`timescale 1ns/100ps
module fcsr_regs
  import fcsr_pkg::*;
(
  input  wire logic      i_sys_clk,
  input  wire logic      i_reset,
  input  wire fcsr_nv_s  i_nv_image,
  input  wire logic      i_cfg_wr_valid,
  input  wire fcsr_cfg_s i_cfg_wr_data,
  input  wire logic      i_sr2_wr_valid,
  input  wire fcsr_sr2_s i_sr2_wr_data,
  input  wire logic      i_write_enable_latch,
  input  wire logic      i_bp_change_req,
  input  wire logic      i_otp_change_req,
  input  wire logic      i_erase_suspended,
  input  wire logic      i_program_suspended,
  input  wire logic      i_io3_pin,
  input  wire logic      i_io3_data_phase,
  output fcsr_cfg_s      o_cfg,
  output fcsr_sr2_s      o_sr2,
  output logic           o_ready,
  output logic           o_write_refused,
  output logic           o_nv_write,
  output fcsr_nv_s       o_nv_data,
  output logic           o_bp_change_ok,
  output logic           o_otp_change_ok,
  output logic [1:0]     o_latency_code,
  output logic           o_protect_from_low,
  output logic           o_param_at_top,
  output logic           o_quad_mode,
  output logic           o_erase_256k,
  output logic           o_wrap_512,
  output logic           o_io3_reset_n,
  output logic           o_hold_n
);

  ////////////////////////////////////////////////////////////////////////////
  // state and register storage

  fcsr_state_e state;
  fcsr_state_e next_state;
  fcsr_cfg_s   cfg;
  fcsr_cfg_s   next_cfg;
  fcsr_sr2_s   sr2;
  fcsr_sr2_s   next_sr2;
  logic        io3_sync;

  ////////////////////////////////////////////////////////////////////////////
  // decode of write requests

  wire logic any_write;
  wire logic write_ok;
  wire logic cfg_take;
  wire logic sr2_take;
  wire logic in_idle;
  wire logic in_load;
  wire logic uniform_layout;

  assign in_idle   = (state == FCSR_ST_IDLE);
  assign in_load   = (state == FCSR_ST_LOAD);
  assign any_write = i_cfg_wr_valid | i_sr2_wr_valid;
  // writes during load or commit are dropped; the nv image must stay whole
  assign write_ok  = in_idle & i_write_enable_latch; // R10
  assign cfg_take  = i_cfg_wr_valid & write_ok; // R10
  assign sr2_take  = i_sr2_wr_valid & write_ok; // R10

  assign uniform_layout = sr2.erase_size_select;

  ////////////////////////////////////////////////////////////////////////////
  // next configuration value

  wire logic       frozen;
  wire logic       next_origin;
  wire logic       next_location;
  wire logic       next_bp_volatile;
  wire logic       next_freeze;

  assign frozen = cfg.freeze;

  // otp bits can only be raised; freeze blocks the raise of origin and location, not of bp_volatile_select
  assign next_origin = frozen ? cfg.protect_origin_select
    : (cfg.protect_origin_select | i_cfg_wr_data.protect_origin_select); // R5 R11
  assign next_location = frozen ? cfg.param_sector_location
    : (cfg.param_sector_location | i_cfg_wr_data.param_sector_location); // R5 R11
  assign next_bp_volatile =
    cfg.bp_volatile_select | i_cfg_wr_data.bp_volatile_select; // R11
  // freeze stays set until reset, so software cannot unlock itself
  assign next_freeze = cfg.freeze | i_cfg_wr_data.freeze; // R5

  always_comb
  begin
    next_cfg = cfg;
    if (in_load)
    begin
      next_cfg        = i_nv_image.cfg; // R11
      next_cfg.freeze = 1'b0;
      next_cfg.reserved = 1'b0;
    end
    else if (cfg_take)
    begin
      next_cfg.latency_code          = i_cfg_wr_data.latency_code; // R1
      next_cfg.protect_origin_select = next_origin;
      next_cfg.reserved              = 1'b0;
      next_cfg.bp_volatile_select    = next_bp_volatile;
      next_cfg.param_sector_location = next_location;
      next_cfg.quad_enable           = i_cfg_wr_data.quad_enable; // R4
      next_cfg.freeze                = next_freeze;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next second status value

  always_comb
  begin
    next_sr2 = sr2;
    if (in_load)
    begin
      next_sr2.erase_size_select   = i_nv_image.sr2.erase_size_select; // R11
      next_sr2.page_wrap_select    = i_nv_image.sr2.page_wrap_select;
      next_sr2.io3_function_select = i_nv_image.sr2.io3_function_select;
    end
    else if (sr2_take)
    begin
      next_sr2.erase_size_select = sr2.erase_size_select
        | i_sr2_wr_data.erase_size_select; // R11
      next_sr2.page_wrap_select = sr2.page_wrap_select
        | i_sr2_wr_data.page_wrap_select; // R11
      next_sr2.io3_function_select = sr2.io3_function_select
        | i_sr2_wr_data.io3_function_select; // R11
    end
    // suspend flags follow the engine and ignore any write
    next_sr2.reserved               = 3'h0;
    next_sr2.erase_suspended_flag   = i_erase_suspended; // R8
    next_sr2.program_suspended_flag = i_program_suspended; // R9
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencing: load image, serve writes, commit image

  always_comb
  begin
    next_state = state;
    case (state)
      FCSR_ST_LOAD:
      begin
        next_state = FCSR_ST_IDLE;
      end
      FCSR_ST_IDLE:
      begin
        if (cfg_take | sr2_take)
        begin
          next_state = FCSR_ST_COMMIT;
        end
      end
      FCSR_ST_COMMIT:
      begin
        next_state = FCSR_ST_IDLE;
      end
      default:
      begin
        next_state = FCSR_ST_LOAD;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      state <= FCSR_ST_LOAD;
      cfg   <= fcsr_cfg_s'(FCSR_CFG_RESET);
      sr2   <= fcsr_sr2_s'(FCSR_SR2_RESET);
    end
    else
    begin
      state <= next_state;
      cfg   <= next_cfg;
      sr2   <= next_sr2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // non-volatile commit and refusal report

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      o_nv_write      <= 1'b0;
      o_nv_data       <= '0;
      o_write_refused <= 1'b0;
    end
    else
    begin
      // image is written one cycle after the registers took the write
      o_nv_write      <= (state == FCSR_ST_COMMIT); // R11
      o_nv_data.cfg   <= cfg;
      o_nv_data.sr2   <= sr2;
      o_write_refused <= any_write & ~write_ok; // R10
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // io3 pin: synchronised, then routed by its function select

  fcsr_sync2 #(
    .WIDTH (FCSR_SYNC_WIDTH)
  ) u_io3_sync (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .i_async   (i_io3_pin),
    .o_sync    (io3_sync)
  );

  wire logic io3_is_control;
  wire logic next_io3_reset_n;
  wire logic next_hold_n;

  // in quad mode the pin carries data during data phases and is ignored
  assign io3_is_control = ~(cfg.quad_enable & i_io3_data_phase);
  assign next_io3_reset_n = ~(io3_is_control & sr2.io3_function_select
    & ~io3_sync); // R7
  assign next_hold_n = ~(io3_is_control & ~sr2.io3_function_select
    & ~io3_sync); // R7

  ////////////////////////////////////////////////////////////////////////////
  // decoded controls, all registered

  wire logic next_bp_change_ok;
  wire logic next_otp_change_ok;

  assign next_bp_change_ok  = i_bp_change_req & ~cfg.freeze
    & i_write_enable_latch; // R5 R10
  assign next_otp_change_ok = i_otp_change_req & ~cfg.freeze
    & i_write_enable_latch; // R5 R10

  // decoded copies are registered so their users see clean levels
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      o_latency_code     <= 2'h0;
      o_protect_from_low <= 1'b0;
      o_param_at_top     <= 1'b0;
      o_quad_mode        <= 1'b0;
      o_erase_256k       <= 1'b0;
      o_wrap_512         <= 1'b0;
    end
    else
    begin
      o_latency_code     <= cfg.latency_code; // R1
      o_protect_from_low <= cfg.protect_origin_select; // R2
      // uniform layout has no parameter sectors, so the bit is ignored
      o_param_at_top     <= cfg.param_sector_location
        & ~uniform_layout; // R3
      o_quad_mode        <= cfg.quad_enable; // R4
      o_erase_256k       <= sr2.erase_size_select; // R6
      o_wrap_512         <= sr2.page_wrap_select;
    end
  end

  // io3 controls idle high, so reset never looks like a pin event
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      o_io3_reset_n <= 1'b1;
      o_hold_n      <= 1'b1;
    end
    else
    begin
      o_io3_reset_n <= next_io3_reset_n; // R7
      o_hold_n      <= next_hold_n; // R7
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // protect checks: a request in the cycle that writes freeze is still granted

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      o_bp_change_ok  <= 1'b0;
      o_otp_change_ok <= 1'b0;
    end
    else
    begin
      o_bp_change_ok  <= next_bp_change_ok; // R5
      o_otp_change_ok <= next_otp_change_ok; // R5
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read-back

  assign o_cfg   = cfg;
  assign o_sr2   = sr2; // R8 R9
  assign o_ready = in_idle;

endmodule : fcsr_regs

// file: testbench/fcsr_regs_properties.sv
`timescale 1ns/100ps
module fcsr_regs_properties
  import fcsr_pkg::*;
(
  input wire logic      i_sys_clk,
  input wire logic      i_reset,
  input wire logic      i_cfg_wr_valid,
  input wire fcsr_cfg_s i_cfg_wr_data,
  input wire logic      i_sr2_wr_valid,
  input wire logic      i_write_enable_latch,
  input wire logic      i_erase_suspended,
  input wire logic      i_program_suspended,
  input wire logic      i_io3_pin,
  input wire logic      i_io3_data_phase,
  input wire fcsr_cfg_s o_cfg,
  input wire fcsr_sr2_s o_sr2,
  input wire logic      o_ready,
  input wire logic      o_write_refused,
  input wire logic      o_nv_write,
  input wire fcsr_nv_s  o_nv_data,
  input wire logic [1:0] o_latency_code,
  input wire logic      o_protect_from_low,
  input wire logic      o_param_at_top,
  input wire logic      o_quad_mode,
  input wire logic      o_erase_256k,
  input wire logic      o_io3_reset_n,
  input wire logic      o_hold_n
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  wire logic any_wr = i_cfg_wr_valid | i_sr2_wr_valid;
  wire logic take   = any_wr & o_ready & i_write_enable_latch;
  ////////////////////////////////////////
  refuse_wr_a: assert property (any_wr && !take |=> o_write_refused)
    else $error("write not refused");
  hold_cfg_a: assert property (any_wr && o_ready && !i_write_enable_latch
    |=> $stable(o_cfg)) else $error("refused write changed config");
  take_cfg_a: assert property (take && i_cfg_wr_valid |=>
    o_cfg.latency_code == $past(i_cfg_wr_data.latency_code)
    && o_cfg.quad_enable == $past(i_cfg_wr_data.quad_enable))
    else $error("config write lost");
  commit_a: assert property (take |=> !o_ready ##1
    o_nv_write && o_nv_data.cfg == o_cfg) else $error("commit wrong");
  freeze_stick_a: assert property (o_cfg.freeze |=> o_cfg.freeze)
    else $error("freeze dropped");
  freeze_block_a: assert property (o_cfg.freeze
    && !o_cfg.param_sector_location |=> !o_cfg.param_sector_location)
    else $error("frozen bit raised");
  otp_keep_a: assert property (o_cfg.protect_origin_select
    |=> o_cfg.protect_origin_select) else $error("otp bit cleared");
  decode_cfg_a: assert property ($rose(o_nv_write) |->
    o_latency_code == o_cfg.latency_code && o_quad_mode == o_cfg.quad_enable
    && o_protect_from_low == o_cfg.protect_origin_select)
    else $error("config decode wrong");
  decode_layout_a: assert property ($rose(o_nv_write) |->
    o_erase_256k == o_sr2.erase_size_select && o_param_at_top ==
    (o_cfg.param_sector_location && !o_sr2.erase_size_select))
    else $error("layout decode wrong");
  erase_susp_a: assert property (o_sr2.erase_suspended_flag
    == $past(i_erase_suspended)) else $error("erase flag wrong");
  prog_susp_a: assert property (o_sr2.program_suspended_flag
    == $past(i_program_suspended)) else $error("program flag wrong");
  io3_reset_a: assert property ((!i_io3_pin && !i_io3_data_phase)[*4]
    ##0 o_sr2.io3_function_select |-> !o_io3_reset_n && o_hold_n)
    else $error("io3 reset missed");
  io3_hold_a: assert property ((!i_io3_pin && !i_io3_data_phase)[*4]
    ##0 !o_sr2.io3_function_select |-> !o_hold_n && o_io3_reset_n)
    else $error("io3 hold missed");
endmodule : fcsr_regs_properties

bind fcsr_regs fcsr_regs_properties i_fcsr_regs_properties (.i_sys_clk,
  .i_reset, .i_cfg_wr_valid, .i_cfg_wr_data, .i_sr2_wr_valid,
  .i_write_enable_latch, .i_erase_suspended, .i_program_suspended,
  .i_io3_pin, .i_io3_data_phase, .o_cfg, .o_sr2, .o_ready,
  .o_write_refused, .o_nv_write, .o_nv_data, .o_latency_code,
  .o_protect_from_low, .o_param_at_top, .o_quad_mode, .o_erase_256k,
  .o_io3_reset_n, .o_hold_n);

// file: testbench/fcsr_host_model.sv
`timescale 1ns/100ps
module fcsr_host_model
  import fcsr_pkg::*;
(
  input  wire logic i_sys_clk,
  input  wire logic i_ready,
  output logic      o_cfg_wr_valid,
  output fcsr_cfg_s o_cfg_wr_data,
  output logic      o_sr2_wr_valid,
  output fcsr_sr2_s o_sr2_wr_data,
  output logic      o_latch
);
  initial
  begin
    o_cfg_wr_valid = 1'b0;
    o_sr2_wr_valid = 1'b0;
    o_cfg_wr_data  = 8'h00;
    o_sr2_wr_data  = 8'h00;
    o_latch        = 1'b0;
  end
  // the latch level stays after the command, as a real host leaves it
  task automatic wr(input logic sel, input logic [7:0] d, input logic le);
    // a ready that never comes is left to the bench watchdog
    @(negedge i_sys_clk);
    while (i_ready !== 1'b1)
    begin
      @(negedge i_sys_clk);
    end
    o_latch        = le;
    o_cfg_wr_data  = d;
    o_sr2_wr_data  = d;
    o_cfg_wr_valid = !sel;
    o_sr2_wr_valid = sel;
    @(negedge i_sys_clk);
    o_cfg_wr_valid = 1'b0;
    o_sr2_wr_valid = 1'b0;
    // released data shows a changed pattern, never the stale byte
    o_cfg_wr_data  = ~d;
    o_sr2_wr_data  = ~d;
  endtask : wr
endmodule : fcsr_host_model

// file: testbench/fcsr_regs_test.sv
`timescale 1ns/100ps
module fcsr_regs_test
  import fcsr_pkg::*;
;
  logic       i_sys_clk = 1'b0;
  logic       i_reset   = 1'b1;
  fcsr_nv_s   nv        = 16'h4324;
  logic       bp_req = 1'b0, otp_req = 1'b0, esus = 1'b0, psus = 1'b0;
  logic       io3_pin = 1'b1, io3_dp = 1'b0;
  logic       cfg_v, sr2_v, latch, ready, refused, nv_wr, bp_ok, otp_ok;
  logic       low, top, quad, e256, wrap, rst_n, hold_n;
  logic [1:0] lat;
  fcsr_cfg_s  cfg, cfg_d;
  fcsr_sr2_s  sr2, sr2_d;
  fcsr_nv_s   nv_data;
  int         n_fail = 0, checks_done = 0;

  always #50 i_sys_clk = ~i_sys_clk;

  fcsr_host_model i_fcsr_host_model (.i_sys_clk(i_sys_clk), .i_ready(ready),
    .o_cfg_wr_valid(cfg_v), .o_cfg_wr_data(cfg_d), .o_sr2_wr_valid(sr2_v),
    .o_sr2_wr_data(sr2_d), .o_latch(latch));
  fcsr_regs i_fcsr_regs (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
    .i_nv_image(nv), .i_cfg_wr_valid(cfg_v), .i_cfg_wr_data(cfg_d),
    .i_sr2_wr_valid(sr2_v), .i_sr2_wr_data(sr2_d),
    .i_write_enable_latch(latch), .i_bp_change_req(bp_req),
    .i_otp_change_req(otp_req), .i_erase_suspended(esus),
    .i_program_suspended(psus), .i_io3_pin(io3_pin),
    .i_io3_data_phase(io3_dp), .o_cfg(cfg), .o_sr2(sr2), .o_ready(ready),
    .o_write_refused(refused), .o_nv_write(nv_wr), .o_nv_data(nv_data),
    .o_bp_change_ok(bp_ok), .o_otp_change_ok(otp_ok), .o_latency_code(lat),
    .o_protect_from_low(low), .o_param_at_top(top), .o_quad_mode(quad),
    .o_erase_256k(e256), .o_wrap_512(wrap), .o_io3_reset_n(rst_n),
    .o_hold_n(hold_n));
  ////////////////////////////////////////
  task automatic chk(input logic [15:0] act, input logic [15:0] exp);
    checks_done++;
    if (act !== exp)
    begin
      n_fail++;
      $display("ERROR at %0t: got %h expected %h", $time, act, exp);
    end
  endtask : chk

  task automatic end_sim;
    if (n_fail == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim

  // image is taken once after reset, decode lands one edge later
  task automatic t_reset;
    i_reset = 1'b1;
    repeat (10) @(negedge i_sys_clk);
    i_reset = 1'b0;
    repeat (4) @(negedge i_sys_clk);
    chk(cfg, nv.cfg & 8'hFE);
    chk(sr2, nv.sr2 & 8'hE0);
    chk(lat, 2'b01);
    chk(quad, 1'b1);
  endtask : t_reset

  task automatic t_refuse;
    i_fcsr_host_model.wr(1'b0, 8'hFF, 1'b0);
    chk(refused, 1'b1);
    chk(cfg, 8'h42);
  endtask : t_refuse

  task automatic t_freeze;
    i_fcsr_host_model.wr(1'b0, 8'h42, 1'b1);
    bp_req  = 1'b1;
    otp_req = 1'b1;
    @(negedge i_sys_clk);
    chk({bp_ok, otp_ok}, 2'b11);
    i_fcsr_host_model.wr(1'b0, 8'h01, 1'b1);
    chk(cfg, 8'h01);
    i_fcsr_host_model.wr(1'b0, 8'hE6, 1'b1);
    chk(cfg, 8'hC3);
    @(negedge i_sys_clk);
    chk({bp_ok, otp_ok}, 2'b00);
    bp_req  = 1'b0;
    otp_req = 1'b0;
  endtask : t_freeze

  task automatic t_io3(input logic dp, input logic [1:0] exp);
    io3_pin = 1'b0;
    io3_dp  = dp;
    repeat (4) @(negedge i_sys_clk);
    chk({rst_n, hold_n}, exp);
    io3_pin = 1'b1;
    io3_dp  = 1'b0;
    repeat (4) @(negedge i_sys_clk);
  endtask : t_io3

  task automatic t_suspend;
    esus = 1'b1;
    @(negedge i_sys_clk);
    chk(sr2[1:0], 2'b10);
    esus = 1'b0;
    psus = 1'b1;
    @(negedge i_sys_clk);
    chk(sr2[1:0], 2'b01);
    psus = 1'b0;
  endtask : t_suspend

  task automatic t_otp;
    i_fcsr_host_model.wr(1'b0, 8'hA4, 1'b1);
    chk(cfg, 8'hA4);
    @(negedge i_sys_clk);
    chk({nv_wr, nv_data.cfg}, 9'h1A4);
    chk({lat, low, top, quad}, 5'b10110);
    i_fcsr_host_model.wr(1'b0, 8'h00, 1'b1);
    chk(cfg, 8'h24);
  endtask : t_otp

  // uniform erase size hides the parameter sectors
  task automatic t_sr2;
    i_fcsr_host_model.wr(1'b1, 8'hC0, 1'b1);
    chk(sr2, 8'hC0);
    @(negedge i_sys_clk);
    chk({e256, wrap, top}, 3'b110);
    chk({nv_wr, nv_data.sr2}, 9'h1C0);
  endtask : t_sr2
  ////////////////////////////////////////
  initial
  begin
    t_reset;
    t_refuse;
    t_freeze;
    t_io3(1'b0, 2'b01);
    t_io3(1'b1, 2'b11);
    t_suspend;
    nv = 16'h4200;
    t_reset;
    t_otp;
    t_sr2;
    t_io3(1'b0, 2'b10);
    end_sim;
  end

  initial
  begin
    #(400 * 100);
    n_fail++;
    end_sim;
  end
endmodule : fcsr_regs_test
